// >>> hw/axil_slave.sv
// axi4-lite slave front end: handshakes, write strobe and registered read answer
`default_nettype none
`include "flash_ctl_regs.svh"
module axil_slave
   import flash_ctl_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address and data
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   // write response
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // read address and data
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // register file side
   output logic wr_en,
   output reg_wr_type wr,
   input wire logic wr_hit,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_hit
);

   logic aw_have_r;
   logic w_have_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   assign wr_en = aw_have_r & w_have_r & ~s_bvalid;
   assign wr = '{addr: awaddr_r, data: wdata_r, strb: wstrb_r};
   assign rd_addr = s_araddr;

   // address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         s_awready <= 1'b1;
         awaddr_r <= 8'h00;
      end else if (s_awvalid && s_awready) begin
         aw_have_r <= 1'b1;
         s_awready <= 1'b0;
         awaddr_r <= s_awaddr;
      end else if (s_bvalid && s_bready) begin
         aw_have_r <= 1'b0;
         s_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         s_wready <= 1'b1;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (s_wvalid && s_wready) begin
         w_have_r <= 1'b1;
         s_wready <= 1'b0;
         wdata_r <= s_wdata;
         wstrb_r <= s_wstrb;
      end else if (s_bvalid && s_bready) begin
         w_have_r <= 1'b0;
         s_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp <= `RESP_OKAY;
      end else if (wr_en) begin
         s_bvalid <= 1'b1;
         s_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= `RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rdata <= rd_hit ? rd_data : 32'h0000_0000;
         s_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
      end
   end

endmodule : axil_slave
`default_nettype wire

// >>> hw/flash_ctl_pkg.sv
// types shared by the flash host controller modules
`default_nettype none
package flash_ctl_pkg;

   typedef enum logic [2:0] {
      OP_READ  = 3'b000,
      OP_WRITE = 3'b001,
      OP_PROG  = 3'b010,
      OP_RESET = 3'b011
   } op_type;

   typedef enum logic [2:0] {
      M_IDLE    = 3'b000,
      M_RST_LOW = 3'b001,
      M_RST_REC = 3'b010,
      M_ISSUE   = 3'b011,
      M_WAIT    = 3'b100
   } main_state_type;

   typedef enum logic [1:0] {
      E_IDLE   = 2'b00,
      E_SETUP  = 2'b01,
      E_STROBE = 2'b10,
      E_HOLD   = 2'b11
   } eng_state_type;

   typedef struct packed {
      logic wr;
      logic [21:0] addr;
      logic [15:0] data;
   } cyc_req_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } reg_wr_type;

endpackage : flash_ctl_pkg
`default_nettype wire

// >>> hw/flash_ctl_regs.svh
// register offsets, field positions and timing counts of the flash host controller
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// register byte offsets
`define OFF_CTRL    8'h00
`define OFF_CMD     8'h04
`define OFF_ADDR    8'h08
`define OFF_WDATA   8'h0c
`define OFF_RDATA   8'h10
`define OFF_STATUS  8'h14
`define OFF_UNLOCK0 8'h18
`define OFF_UNLOCK1 8'h1c

// ctrl fields
`define CTRL_BYTE 0
`define CTRL_WP   1
`define CTRL_HV   2
`define CTRL_BYP  3
`define CTRL_W    4
`define CTRL_RST  4'h2

// cmd fields
`define CMD_OP_HI   2
`define CMD_OP_LO   0
`define CMD_CODE_HI 15
`define CMD_CODE_LO 8

// status fields
`define ST_BUSY 0
`define ST_DONE 1
`define ST_RYBY 2

// unlock word layout: address low, data byte above
`define UNL_A_HI 21
`define UNL_D_HI 29
`define UNL_D_LO 22

// axi responses
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

// sequence lengths
`define SEQ_NORMAL 3'h4
`define SEQ_BYPASS 3'h2

// timing in ns and derived cycle counts at the clock rate
`define CLK_NS    50
`define T_ACC_NS  70
`define T_WP_NS   35
`define T_RP_NS   500
`define T_RH_NS   50
`define ACC_CYC   ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC    ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define RP_CYC    ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define RH_CYC    ((`T_RH_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> hw/flash_cycle.sv
// one asynchronous flash bus cycle, read or write, on registered pins
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_cycle
   import flash_ctl_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // request
   input wire logic start,
   input wire cyc_req_type req,
   input wire logic byte_mode,
   output logic done,
   output logic [15:0] rdata,
   // flash pins
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [20:0] addr_pins,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic [15:0] data_oe_n
);

   eng_state_type state_r;
   cyc_req_type req_r;
   logic [7:0] cnt_r;
   logic drive_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= E_IDLE;
         req_r <= '0;
         cnt_r <= 8'h00;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_r)
            E_IDLE: begin
               if (start) begin
                  req_r <= req;
                  state_r <= E_SETUP;
               end
            end
            E_SETUP: begin
               cnt_r <= req_r.wr ? 8'(`WP_CYC) : 8'(`ACC_CYC);
               state_r <= E_STROBE;
            end
            E_STROBE: begin
               if (cnt_r == 8'h01) begin
                  state_r <= E_HOLD;
               end
               cnt_r <= cnt_r - 8'h01;
            end
            E_HOLD: begin
               done <= 1'b1;
               state_r <= E_IDLE;
            end
            default: state_r <= E_IDLE;
         endcase
      end
   end

   // control strobes: read is ce and oe low with we high, write is ce and we low with oe high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
      end else begin
         ce_n <= !((state_r == E_IDLE && start) || state_r == E_SETUP || state_r == E_STROBE);
         oe_n <= !(state_r == E_SETUP && !req_r.wr) && !(state_r == E_STROBE && !req_r.wr && cnt_r != 8'h01);
         we_n <= !(state_r == E_SETUP && req_r.wr) && !(state_r == E_STROBE && req_r.wr && cnt_r != 8'h01);
      end
   end

   // byte mode puts the address one bit down, its lowest bit leaving on the top data pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_pins <= 21'h00_0000;
      end else if (state_r == E_IDLE && start) begin
         addr_pins <= byte_mode ? req.addr[21:1] : req.addr[20:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata <= 16'h0000;
      end else if (state_r == E_STROBE && !req_r.wr && cnt_r == 8'h01) begin
         rdata <= byte_mode ? {8'h00, data_in[7:0]} : data_in;
      end
   end

   // write data stands from setup until the strobe has risen
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_r <= 1'b0;
      end else begin
         drive_r <= (state_r == E_IDLE && start && req.wr) || ((state_r == E_SETUP || state_r == E_STROBE) && req_r.wr);
      end
   end

   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_dq
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               data_out[i] <= 1'b0;
               data_oe_n[i] <= 1'b1;
            end else if (i == 15 && byte_mode) begin
               data_out[i] <= (state_r == E_IDLE && start) ? req.addr[0] : data_out[i];
               data_oe_n[i] <= 1'b0;
            end else begin
               data_out[i] <= (state_r == E_IDLE && start) ? req.data[i] : data_out[i];
               data_oe_n[i] <= !(drive_r || (state_r == E_IDLE && start && req.wr)) || (byte_mode && i >= 8);
            end
         end
      end
   endgenerate

endmodule : flash_cycle
`default_nettype wire

// >>> hw/flash_host.sv
// host controller for an asynchronous parallel flash, driven by software over axi4-lite
// Functional notes
// - reads drive chip select and output gate low, write strobe held high.
// - commands drive write strobe and chip select low, output gate held high.
// - address is bits twenty..zero in word mode, twenty..minus one in byte mode.
// - in unlock bypass a program takes two write cycles instead of four.
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_host
   import flash_ctl_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   // axi4-lite write response
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // flash control pins
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic flash_reset_n,
   output logic byte_n,
   output logic protect_accel_pin,
   output logic accel_high_voltage,
   input wire logic ready_busy_n,
   // flash address and data pins
   output logic [20:0] addr_pins,
   input wire logic [15:0] data_pins_in,
   output logic [15:0] data_pins_out,
   output logic [15:0] data_pins_oe_n
);

   logic wr_en;
   reg_wr_type wr;
   logic wr_hit;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_hit;

   logic [`CTRL_W-1:0] ctrl_r;
   logic [7:0] code_r;
   logic [21:0] addr_r;
   logic [15:0] wdata_r;
   logic [29:0] unlock0_r;
   logic [29:0] unlock1_r;
   logic [15:0] rdata_r;
   logic done_r;
   main_state_type state_r;
   op_type op_r;
   logic [7:0] cnt_r;
   logic [2:0] step_r;
   logic [2:0] seq_len;
   logic [2:0] step_eff;
   logic start_r;
   cyc_req_type req;
   logic eng_done;
   logic [15:0] eng_rdata;
   logic busy;
   logic cmd_go;
   logic bypass;

   axil_slave u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_en(wr_en),
      .wr(wr),
      .wr_hit(wr_hit),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_hit(rd_hit)
   );

   flash_cycle u_cycle (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(start_r),
      .req(req),
      .byte_mode(ctrl_r[`CTRL_BYTE]),
      .done(eng_done),
      .rdata(eng_rdata),
      .ce_n(ce_n),
      .oe_n(oe_n),
      .we_n(we_n),
      .addr_pins(addr_pins),
      .data_in(data_pins_in),
      .data_out(data_pins_out),
      .data_oe_n(data_pins_oe_n)
   );

   assign busy = (state_r != M_IDLE);
   assign cmd_go = wr_en && wr.addr == `OFF_CMD && wr.strb[0] && !busy;

   // the elevated protect level puts the device in bypass by itself
   assign bypass = ctrl_r[`CTRL_BYP] || ctrl_r[`CTRL_HV];
   assign seq_len = bypass ? `SEQ_BYPASS : `SEQ_NORMAL;
   assign step_eff = bypass ? step_r + 3'h2 : step_r;

   // write decode; ctrl, addresses and data are frozen while an operation runs
   always_comb begin
      if (wr.addr == `OFF_CTRL || wr.addr == `OFF_CMD || wr.addr == `OFF_ADDR) begin
         wr_hit = 1'b1;
      end else if (wr.addr == `OFF_WDATA || wr.addr == `OFF_UNLOCK0 || wr.addr == `OFF_UNLOCK1) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `CTRL_RST;
      end else if (wr_en && wr.addr == `OFF_CTRL && wr.strb[0] && !busy) begin
         ctrl_r <= wr.data[`CTRL_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_r <= 22'h00_0000;
         wdata_r <= 16'h0000;
         unlock0_r <= 30'h0000_0000;
         unlock1_r <= 30'h0000_0000;
      end else if (wr_en && !busy) begin
         if (wr.addr == `OFF_ADDR) begin
            addr_r <= wr.data[21:0];
         end else if (wr.addr == `OFF_WDATA) begin
            wdata_r <= wr.data[15:0];
         end else if (wr.addr == `OFF_UNLOCK0) begin
            unlock0_r <= wr.data[29:0];
         end else if (wr.addr == `OFF_UNLOCK1) begin
            unlock1_r <= wr.data[29:0];
         end
      end
   end

   // read decode
   always_comb begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      if (rd_addr == `OFF_CTRL) begin
         rd_data[`CTRL_W-1:0] = ctrl_r;
      end else if (rd_addr == `OFF_CMD) begin
         rd_data[`CMD_CODE_HI:`CMD_CODE_LO] = code_r;
         rd_data[`CMD_OP_HI:`CMD_OP_LO] = op_r;
      end else if (rd_addr == `OFF_ADDR) begin
         rd_data[21:0] = addr_r;
      end else if (rd_addr == `OFF_WDATA) begin
         rd_data[15:0] = wdata_r;
      end else if (rd_addr == `OFF_RDATA) begin
         rd_data[15:0] = rdata_r;
      end else if (rd_addr == `OFF_STATUS) begin
         rd_data[`ST_BUSY] = busy;
         rd_data[`ST_DONE] = done_r;
         rd_data[`ST_RYBY] = ready_busy_n;
      end else if (rd_addr == `OFF_UNLOCK0) begin
         rd_data[29:0] = unlock0_r;
      end else if (rd_addr == `OFF_UNLOCK1) begin
         rd_data[29:0] = unlock1_r;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // cycle request for the current step; a program runs unlock, unlock, code, data, or only code, data in bypass
   always_comb begin
      req = '0;
      if (op_r == OP_READ) begin
         req.addr = addr_r;
      end else if (op_r == OP_WRITE) begin
         req.wr = 1'b1;
         req.addr = addr_r;
         req.data = wdata_r;
      end else begin
         req.wr = 1'b1;
         case (step_eff)
            3'h0: begin
               req.addr = unlock0_r[`UNL_A_HI:0];
               req.data = {8'h00, unlock0_r[`UNL_D_HI:`UNL_D_LO]};
            end
            3'h1: begin
               req.addr = unlock1_r[`UNL_A_HI:0];
               req.data = {8'h00, unlock1_r[`UNL_D_HI:`UNL_D_LO]};
            end
            3'h2: begin
               req.addr = unlock0_r[`UNL_A_HI:0];
               req.data = {8'h00, code_r};
            end
            default: begin
               req.addr = addr_r;
               req.data = wdata_r;
            end
         endcase
      end
   end

   // operation sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= M_IDLE;
         op_r <= OP_READ;
         code_r <= 8'h00;
         cnt_r <= 8'h00;
         step_r <= 3'h0;
         start_r <= 1'b0;
      end else begin
         start_r <= 1'b0;
         case (state_r)
            M_IDLE: begin
               if (cmd_go) begin
                  op_r <= op_type'(wr.data[`CMD_OP_HI:`CMD_OP_LO]);
                  code_r <= wr.data[`CMD_CODE_HI:`CMD_CODE_LO];
                  step_r <= 3'h0;
                  if (op_type'(wr.data[`CMD_OP_HI:`CMD_OP_LO]) == OP_RESET) begin
                     cnt_r <= 8'(`RP_CYC);
                     state_r <= M_RST_LOW;
                  end else begin
                     state_r <= M_ISSUE;
                  end
               end
            end
            M_RST_LOW: begin
               if (cnt_r == 8'h01) begin
                  cnt_r <= 8'(`RH_CYC);
                  state_r <= M_RST_REC;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_RST_REC: begin
               if (cnt_r == 8'h01) begin
                  state_r <= M_IDLE;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            M_ISSUE: begin
               start_r <= 1'b1;
               state_r <= M_WAIT;
            end
            M_WAIT: begin
               if (eng_done) begin
                  if (op_r == OP_PROG && step_r + 3'h1 < seq_len) begin
                     step_r <= step_r + 3'h1;
                     state_r <= M_ISSUE;
                  end else begin
                     state_r <= M_IDLE;
                  end
               end
            end
            default: state_r <= M_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_r <= 16'h0000;
      end else if (state_r == M_WAIT && eng_done && op_r == OP_READ) begin
         rdata_r <= eng_rdata;
      end
   end

   // done is cleared by a new command and set when an operation ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= 1'b0;
      end else if (state_r == M_RST_REC && cnt_r == 8'h01) begin
         done_r <= 1'b1;
      end else if (state_r == M_WAIT && eng_done && !(op_r == OP_PROG && step_r + 3'h1 < seq_len)) begin
         done_r <= 1'b1;
      end else if (cmd_go) begin
         done_r <= 1'b0;
      end
   end

   // device reset pin and static mode pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_reset_n <= 1'b1;
         byte_n <= 1'b1;
         protect_accel_pin <= 1'b1;
         accel_high_voltage <= 1'b0;
      end else begin
         flash_reset_n <= !(state_r == M_RST_LOW);
         byte_n <= !ctrl_r[`CTRL_BYTE];
         protect_accel_pin <= ctrl_r[`CTRL_WP];
         accel_high_voltage <= ctrl_r[`CTRL_HV];
      end
   end

endmodule : flash_host
`default_nettype wire

// >>> verification/flash_bus_operation_decode_tb.sv
// self-checking testbench for the flash host controller
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_bus_operation_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic [7:0] s_awaddr = 0, s_araddr = 0;
   logic [31:0] s_wdata = 0, s_rdata, rd;
   logic [3:0] s_wstrb = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp, rs;
   logic ce_n, oe_n, we_n, flash_reset_n, byte_n, wp, hv, rdy;
   logic [20:0] addr_pins;
   logic [15:0] dq, d_out, d_oe_n;
   int bad_count = 0, tests_run = 0, we_cnt = 0, rlow = 0, w0;
   always #25 aclk = ~aclk;
   always @(negedge we_n) we_cnt++;
   always @(posedge aclk) if (!flash_reset_n) rlow++;
   flash_host uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
      .ce_n, .oe_n, .we_n, .flash_reset_n, .byte_n, .protect_accel_pin(wp), .accel_high_voltage(hv),
      .ready_busy_n(rdy), .addr_pins, .data_pins_in(dq), .data_pins_out(d_out), .data_pins_oe_n(d_oe_n));
   flash_dev_model dev (.aclk, .ce_n, .oe_n, .we_n, .rst_n(flash_reset_n), .byte_n, .wp, .hv, .addr(addr_pins),
      .h_out(d_out), .h_oe_n(d_oe_n), .dq, .rdy);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hf;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
      chk(32'(s_bresp), 32'(er));
   endtask : wr
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      s_rready <= 1'b0;
      rd = s_rdata;
      rs = s_rresp;
   endtask : rd_reg
   task automatic run_op(input logic [31:0] cmd);
      wr(`OFF_CMD, cmd);
      do begin
         rd_reg(`OFF_STATUS);
      end while (rd[0] !== 1'b0);
      chk(32'(rd[2:0]), 32'h6);
   endtask : run_op
   task automatic op_read(input logic [31:0] a, input logic [15:0] exp);
      wr(`OFF_ADDR, a);
      run_op(32'h0);
      rd_reg(`OFF_RDATA);
      chk(32'(rs), 32'h0);
      chk(rd, {16'h0, exp});
   endtask : op_read
   task automatic t_reset;
      @(negedge aclk);
      chk(32'({ce_n, oe_n, we_n, flash_reset_n, byte_n}), 32'h1f);
      chk(32'(d_oe_n), 32'hffff);
      rd_reg(`OFF_CTRL);
      chk(rd, 32'h2);
      op_read(32'h3, 16'h1003);
   endtask : t_reset
   task automatic t_program;
      wr(`OFF_UNLOCK0, {2'b0, 8'haa, 22'h000555});
      wr(`OFF_UNLOCK1, {2'b0, 8'h55, 22'h0002aa});
      wr(`OFF_ADDR, 32'h5);
      wr(`OFF_WDATA, 32'hbeef);
      w0 = we_cnt;
      run_op(32'ha002);
      chk(32'(we_cnt - w0), 32'h4);
      op_read(32'h5, 16'hbeef);
      wr(`OFF_CTRL, 32'ha);
      wr(`OFF_ADDR, 32'h6);
      wr(`OFF_WDATA, 32'h1234);
      w0 = we_cnt;
      run_op(32'ha002);
      chk(32'(we_cnt - w0), 32'h2);
      op_read(32'h6, 16'h1234);
   endtask : t_program
   task automatic t_byte;
      wr(`OFF_CTRL, 32'h3);
      @(negedge aclk);
      chk(32'({byte_n, d_oe_n[15:8]}), 32'h7f);
      op_read(32'hb, 16'h00be);
      wr(`OFF_ADDR, 32'hc);
      wr(`OFF_WDATA, 32'h77);
      run_op(32'ha002);
      wr(`OFF_CTRL, 32'h2);
      op_read(32'h6, 16'h1277);
   endtask : t_byte
   task automatic t_misc;
      w0 = we_cnt;
      run_op(32'h1);
      chk(32'(we_cnt - w0), 32'h1);
      rlow = 0;
      run_op(32'h3);
      chk(32'(rlow), 32'(`RP_CYC));
      op_read(32'h3, 16'h1003);
      wr(`OFF_CTRL, 32'h6);
      @(negedge aclk);
      chk(32'({wp, hv}), 32'h3);
      wr(8'h20, 32'h0, 2'b10);
      rd_reg(8'h24);
      chk(32'(rs), 32'h2);
   endtask : t_misc
   task automatic report_and_stop;
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_program();
      t_byte();
      t_misc();
      report_and_stop();
   end
   initial begin
      #1000000;
      bad_count++;
      report_and_stop();
   end
endmodule : flash_bus_operation_decode_tb
`default_nettype wire

// >>> verification/flash_dev_model.sv
// behavioural flash device on the far side of the host controller
`default_nettype none
module flash_dev_model (
   // clock for the float pattern
   input wire logic aclk,
   // control pins
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rst_n,
   input wire logic byte_n,
   input wire logic wp,
   input wire logic hv,
   // address and host data
   input wire logic [20:0] addr,
   input wire logic [15:0] h_out,
   input wire logic [15:0] h_oe_n,
   // resolved data wire and status
   output logic [15:0] dq,
   output logic rdy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [15:0] flt;
   logic [15:0] dv;
   logic [7:0] latch_d;
   logic dev_en;
   initial begin
      flt = 16'h5555;
      latch_d = 8'h00;
      for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
   end
   // undriven lanes change every cycle
   always @(posedge aclk) flt <= ~flt;
   assign rdy = 1'b1;
   assign dev_en = !ce_n && !oe_n && we_n && rst_n;
   always_comb begin
      dv = mem[addr[3:0]];
      if (!byte_n) dv = {flt[15:8], h_out[15] ? dv[15:8] : dv[7:0]};
      for (int b = 0; b < 16; b++) dq[b] = !h_oe_n[b] ? h_out[b] : (dev_en ? dv[b] : flt[b]);
   end
   always @(posedge we_n) begin
      if (!ce_n && rst_n) begin
         if (latch_d == 8'ha0 && (wp || hv || addr[20:15] != 6'h3f)) begin
            if (byte_n) mem[addr[3:0]] = dq;
            else if (dq[15]) mem[addr[3:0]][15:8] = dq[7:0];
            else mem[addr[3:0]][7:0] = dq[7:0];
         end
         latch_d = dq[7:0];
      end
   end
   always @(negedge rst_n) latch_d = 8'h00;
endmodule : flash_dev_model
`default_nettype wire

// >>> verification/flash_host_monitor.sv
// port checker for the flash host controller
`default_nettype none
module flash_host_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi read handshake
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   // flash pins
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic flash_reset_n,
   input wire logic byte_n,
   input wire logic [15:0] data_pins_oe_n
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_read_lv; !oe_n |-> !ce_n && we_n; endproperty
   a_read_lv: assert property (p_read_lv) else $error("output gate low outside a read");
   property p_write_lv; !we_n |-> !ce_n && oe_n; endproperty
   a_write_lv: assert property (p_write_lv) else $error("write strobe low outside a write");
   property p_no_clash; !oe_n |-> &data_pins_oe_n[14:0]; endproperty
   a_no_clash: assert property (p_no_clash) else $error("host drives data while reading");
   property p_byte_lanes; !byte_n && !ce_n |-> !data_pins_oe_n[15] && &data_pins_oe_n[14:8]; endproperty
   a_byte_lanes: assert property (p_byte_lanes) else $error("byte mode lanes wrong");
   property p_word_wr; !we_n && byte_n |-> data_pins_oe_n == 16'h0000; endproperty
   a_word_wr: assert property (p_word_wr) else $error("word write not driving all lanes");
   property p_oe_pulse; $fell(oe_n) |-> (!oe_n) [*2] ##1 oe_n; endproperty
   a_oe_pulse: assert property (p_oe_pulse) else $error("read strobe length wrong");
   property p_we_pulse; $fell(we_n) |=> we_n; endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe length wrong");
   property p_rst_pulse; $fell(flash_reset_n) |-> (!flash_reset_n) [*8]; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
   property p_r_answer; s_arvalid && s_arready |=> s_rvalid; endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   c_read: cover property ($fell(oe_n));
   c_write: cover property ($fell(we_n));
   c_reset: cover property ($fell(flash_reset_n));
   c_byte: cover property (!byte_n && !oe_n);
endmodule : flash_host_monitor
bind flash_host flash_host_monitor mon (.aclk, .aresetn, .s_arvalid, .s_arready, .s_rvalid, .ce_n, .oe_n, .we_n,
   .flash_reset_n, .byte_n, .data_pins_oe_n);
`default_nettype wire
